/* include/mrcs_defs.vh */
`ifndef MRCS_DEFS_VH
`define MRCS_DEFS_VH

// ==========================================================
// Register offsets
`define MRCS_OFS_CTRL 8'h00
`define MRCS_OFS_REPORT 8'h01
`define MRCS_OFS_DTE_RATE 8'h02
`define MRCS_OFS_LAST_CODE 8'h03
`define MRCS_OFS_STATUS 8'h04
`define MRCS_OFS_COUNT 8'h05

// ==========================================================
// Reset values
`define MRCS_RST_CTRL 8'h44
`define MRCS_RST_REPORT 8'h0c
`define MRCS_RST_DTE_RATE 5'h12

// ==========================================================
// Control, report and status field positions
`define MRCS_CTRL_LEVEL_LSB 0
`define MRCS_CTRL_LEVEL_MSB 2
`define MRCS_CTRL_CRS_LSB 3
`define MRCS_CTRL_CRS_MSB 4
`define MRCS_CTRL_QUIET 5
`define MRCS_CTRL_NUMVERB 6
`define MRCS_REP_COMP_EN 0
`define MRCS_REP_PROT_EN 1
`define MRCS_REP_AWAIT_DT 2
`define MRCS_REP_BUSY_ENF 3
`define MRCS_STAT_OVERRUN 7

// ==========================================================
// Connect report select values
`define MRCS_CRS_DTE 2'h0
`define MRCS_CRS_CARRIER 2'h1
`define MRCS_CRS_LINE 2'h2

// ==========================================================
// Rate indices (300 bits/s is index 0, 33600 is index 16)
`define MRCS_RATE_2400 5'h03
`define MRCS_RATE_4800 5'h04
`define MRCS_RATE_7200 5'h05
`define MRCS_RATE_9600 5'h06
`define MRCS_RATE_14400 5'h08
`define MRCS_RATE_16800 5'h09
`define MRCS_RATE_19200 5'h0a
`define MRCS_RATE_33600 5'h10

// ==========================================================
// Carrier modulation encodings
`define MRCS_MOD_V21 4'h0
`define MRCS_MOD_V23_BACK 4'h1
`define MRCS_MOD_V23_FWD 4'h2
`define MRCS_MOD_V22 4'h3
`define MRCS_MOD_V22BIS 4'h4
`define MRCS_MOD_V32 4'h5
`define MRCS_MOD_V32BIS 4'h6
`define MRCS_MOD_V32EXT 4'h7
`define MRCS_MOD_V34 4'h8

// ==========================================================
// Result codes
`define MRCS_CODE_CONNECT 8'h01
`define MRCS_CODE_NO_CARRIER 8'h03
`define MRCS_CODE_NO_DIAL_TONE 8'h06
`define MRCS_CODE_BUSY 8'h07
`define MRCS_CODE_NO_ANSWER 8'h08
`define MRCS_CODE_CAR_300 8'h28
`define MRCS_CODE_CAR_75_1200 8'h2a
`define MRCS_CODE_CAR_1200_75 8'h2b
`define MRCS_CODE_CAR_1200 8'h2e
`define MRCS_CODE_CAR_2400 8'h2f
`define MRCS_CODE_CAR_BASE 8'h2c
`define MRCS_CODE_COMP_CLASS5 8'h42
`define MRCS_CODE_COMP_V42BIS 8'h43
`define MRCS_CODE_COMP_NONE 8'h45
`define MRCS_CODE_PROT_NONE 8'h46
`define MRCS_CODE_PROT_LAPM 8'h4d
`define MRCS_CODE_PROT_ALT_BASE 8'h50

// ==========================================================
// Compression and protocol encodings
`define MRCS_COMP_NONE 2'h0
`define MRCS_COMP_CLASS5 2'h1
`define MRCS_COMP_V42BIS 2'h2
`define MRCS_PROT_NONE 3'h0
`define MRCS_PROT_LAPM 3'h1
`define MRCS_PROT_ALT0 3'h2
`define MRCS_PROT_ALT4 3'h6

`endif

/* logic/mrcs_selector.v */
// Overview of operation
// - Levels two/four: missing dial tone gives 6
// - Levels three/four, busy enforced: engaged gives 7
// - Quiet-answer dial without silence gives 8
// - Levels one-four: connect-rate code when line/2400-DTE reporting
// - Carrier codes 40-60 only with carrier reporting
// - V.21 or 103-type carrier gives 40
// - V.23 backward gives 42, forward 43
// - V.22 or 212-type 1200 gives 46
// - V.22bis or V.34 at 2400 gives 47
// - 4800 gives 48, 9600 gives 50
// - 7200, 12000, 14400 give 49, 51, 52
// - 16800 and 19200 give 53 and 54
// - V.34 21600..33600 give 55..60
// - Compression reporting: 66, 67, 69
// - Protocol reporting: no correction gives 70
// - Protocol reporting: LAPM gives 77
// - Quiet setting suppresses connect messages
// - Numeric select zero reports numeric codes
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mrcs_defs.vh"

module mrcs_selector
(
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire no_dial_tone_i,
  input wire busy_detect_i,
  input wire quiet_answer_mod_i,
  input wire no_silence_timeout_i,
  input wire connect_i,
  input wire [7:0] connect_rate_code_i,
  input wire carrier_det_i,
  input wire [3:0] carrier_mod_i,
  input wire [4:0] carrier_rate_i,
  input wire compress_det_i,
  input wire [1:0] compress_type_i,
  input wire protocol_det_i,
  input wire [2:0] protocol_type_i,
  output reg [7:0] code_o,
  output reg code_valid_o,
  output reg code_numeric_o
);

  localparam NCLS = 7;
  localparam CLS_DIAL = 0;
  localparam CLS_BUSY = 1;
  localparam CLS_NOANS = 2;
  localparam CLS_CARRIER = 3;
  localparam CLS_PROT = 4;
  localparam CLS_COMP = 5;
  localparam CLS_CONNECT = 6;
  localparam [2:0] SEL_NONE = 3'h7;

  // ==========================================================
  // Decode helpers

  // Lowest pending class wins; failures first, then negotiation, connect last
  function [2:0] first_pending;
    input [NCLS-1:0] p;
    integer j;
    begin
      first_pending = SEL_NONE;
      for (j = NCLS - 1; j >= 0; j = j - 1)
      begin
        if (p[j])
        begin
          first_pending = j[2:0];
        end
      end
    end
  endfunction

  // Carrier code, zero where the pair is not a legal combination
  function [7:0] carrier_code;
    input [3:0] m;
    input [4:0] r;
    begin
      carrier_code = 8'h00;
      case (m)
        `MRCS_MOD_V21: carrier_code = `MRCS_CODE_CAR_300;
        `MRCS_MOD_V23_BACK: carrier_code = `MRCS_CODE_CAR_75_1200;
        `MRCS_MOD_V23_FWD: carrier_code = `MRCS_CODE_CAR_1200_75;
        `MRCS_MOD_V22: carrier_code = `MRCS_CODE_CAR_1200;
        `MRCS_MOD_V22BIS: carrier_code = `MRCS_CODE_CAR_2400;
        `MRCS_MOD_V32:
        begin
          if (r == `MRCS_RATE_4800 || r == `MRCS_RATE_9600)
          begin
            carrier_code = `MRCS_CODE_CAR_BASE + {3'h0, r};
          end
        end
        `MRCS_MOD_V32BIS:
        begin
          if (r >= `MRCS_RATE_4800 && r <= `MRCS_RATE_14400)
          begin
            carrier_code = `MRCS_CODE_CAR_BASE + {3'h0, r};
          end
        end
        `MRCS_MOD_V32EXT:
        begin
          if (r == `MRCS_RATE_16800 || r == `MRCS_RATE_19200)
          begin
            carrier_code = `MRCS_CODE_CAR_BASE + {3'h0, r};
          end
        end
        `MRCS_MOD_V34:
        begin
          if (r == `MRCS_RATE_2400)
          begin
            carrier_code = `MRCS_CODE_CAR_2400;
          end
          else if (r >= `MRCS_RATE_4800 && r <= `MRCS_RATE_33600)
          begin
            // Codes 48..60 track the rate index one to one
            carrier_code = `MRCS_CODE_CAR_BASE + {3'h0, r};
          end
        end
        default: carrier_code = 8'h00;
      endcase
    end
  endfunction

  // Connect-rate codes that the rate table may legally hand over
  function is_rate_code;
    input [7:0] c;
    begin
      is_rate_code = (c == 8'h05) || (c >= 8'h0a && c <= 8'h0f) ||
        (c >= 8'h18 && c <= 8'h21);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] ctrl_r;
  reg [7:0] report_r;
  reg [4:0] dte_rate_r;
  reg [7:0] last_code_r;
  reg [7:0] count_r;
  reg overrun_r;

  wire [2:0] result_range_level = ctrl_r[`MRCS_CTRL_LEVEL_MSB:`MRCS_CTRL_LEVEL_LSB];
  wire [1:0] connect_report_select = ctrl_r[`MRCS_CTRL_CRS_MSB:`MRCS_CTRL_CRS_LSB];
  wire quiet_select = ctrl_r[`MRCS_CTRL_QUIET];
  wire numeric_verbose_select = ctrl_r[`MRCS_CTRL_NUMVERB];
  wire comp_en = report_r[`MRCS_REP_COMP_EN];
  wire prot_en = report_r[`MRCS_REP_PROT_EN];
  wire await_dial_tone = report_r[`MRCS_REP_AWAIT_DT];
  wire busy_enforce = report_r[`MRCS_REP_BUSY_ENF];
  wire carrier_en = (connect_report_select == `MRCS_CRS_CARRIER);

  // ==========================================================
  // Event qualification
  reg [NCLS-1:0] ev;
  reg [NCLS*8-1:0] ev_code;
  reg [7:0] car_code;

  always @*
  begin
    ev = {NCLS{1'b0}};
    ev_code = {NCLS*8{1'b0}};
    car_code = carrier_code(carrier_mod_i, carrier_rate_i);

    if (no_dial_tone_i && await_dial_tone)
    begin
      if (result_range_level == 3'h2 || result_range_level == 3'h4)
      begin
        ev[CLS_DIAL] = 1'b1;
        ev_code[CLS_DIAL*8 +: 8] = `MRCS_CODE_NO_DIAL_TONE;
      end
      else if (result_range_level == 3'h0)
      begin
        ev[CLS_DIAL] = 1'b1;
        ev_code[CLS_DIAL*8 +: 8] = `MRCS_CODE_NO_CARRIER;
      end
    end

    if (busy_detect_i && busy_enforce)
    begin
      if (result_range_level == 3'h3 || result_range_level == 3'h4)
      begin
        ev[CLS_BUSY] = 1'b1;
        ev_code[CLS_BUSY*8 +: 8] = `MRCS_CODE_BUSY;
      end
      else if (result_range_level == 3'h0)
      begin
        ev[CLS_BUSY] = 1'b1;
        ev_code[CLS_BUSY*8 +: 8] = `MRCS_CODE_NO_CARRIER;
      end
    end

    if (no_silence_timeout_i && quiet_answer_mod_i)
    begin
      ev[CLS_NOANS] = 1'b1;
      ev_code[CLS_NOANS*8 +: 8] = `MRCS_CODE_NO_ANSWER;
    end

    // Negotiation and connect messages all vanish under the quiet setting
    if (!quiet_select)
    begin
      if (carrier_det_i && carrier_en && car_code != 8'h00)
      begin
        ev[CLS_CARRIER] = 1'b1;
        ev_code[CLS_CARRIER*8 +: 8] = car_code;
      end

      if (protocol_det_i && prot_en)
      begin
        ev[CLS_PROT] = 1'b1;
        if (protocol_type_i == `MRCS_PROT_NONE)
        begin
          ev_code[CLS_PROT*8 +: 8] = `MRCS_CODE_PROT_NONE;
        end
        else if (protocol_type_i == `MRCS_PROT_LAPM)
        begin
          ev_code[CLS_PROT*8 +: 8] = `MRCS_CODE_PROT_LAPM;
        end
        else if (protocol_type_i <= `MRCS_PROT_ALT4)
        begin
          ev_code[CLS_PROT*8 +: 8] = `MRCS_CODE_PROT_ALT_BASE +
            {5'h00, protocol_type_i - `MRCS_PROT_ALT0};
        end
        else
        begin
          ev[CLS_PROT] = 1'b0;
        end
      end

      if (compress_det_i && comp_en)
      begin
        ev[CLS_COMP] = 1'b1;
        if (compress_type_i == `MRCS_COMP_CLASS5)
        begin
          ev_code[CLS_COMP*8 +: 8] = `MRCS_CODE_COMP_CLASS5;
        end
        else if (compress_type_i == `MRCS_COMP_V42BIS)
        begin
          ev_code[CLS_COMP*8 +: 8] = `MRCS_CODE_COMP_V42BIS;
        end
        else if (compress_type_i == `MRCS_COMP_NONE)
        begin
          ev_code[CLS_COMP*8 +: 8] = `MRCS_CODE_COMP_NONE;
        end
        else
        begin
          ev[CLS_COMP] = 1'b0;
        end
      end

      if (connect_i)
      begin
        ev[CLS_CONNECT] = 1'b1;
        ev_code[CLS_CONNECT*8 +: 8] = `MRCS_CODE_CONNECT;
        // Rate code only where speed reporting is allowed; else plain connect
        if (result_range_level >= 3'h1 && result_range_level <= 3'h4 &&
          is_rate_code(connect_rate_code_i) &&
          (connect_report_select == `MRCS_CRS_LINE ||
          (connect_report_select == `MRCS_CRS_DTE &&
          dte_rate_r == `MRCS_RATE_2400)))
        begin
          ev_code[CLS_CONNECT*8 +: 8] = connect_rate_code_i;
        end
      end
    end
  end

  // ==========================================================
  // Pending slots, one per message class
  wire [NCLS-1:0] pend;
  wire [NCLS*8-1:0] pend_code;
  wire [2:0] sel = first_pending(pend);
  wire [NCLS-1:0] grant = (sel == SEL_NONE) ? {NCLS{1'b0}} :
    ({{(NCLS-1){1'b0}}, 1'b1} << sel);

  genvar k;
  generate
    for (k = 0; k < NCLS; k = k + 1)
    begin : g_slot
      reg pend_r;
      reg [7:0] code_r;
      assign pend[k] = pend_r;
      assign pend_code[k*8 +: 8] = code_r;

      // A new event in the grant cycle keeps the slot full
      always @(posedge clock_i)
      begin
        if (rst_i)
        begin
          pend_r <= 1'b0;
          code_r <= 8'h00;
        end
        else if (ev[k])
        begin
          pend_r <= 1'b1;
          code_r <= ev_code[k*8 +: 8];
        end
        else if (grant[k])
        begin
          pend_r <= 1'b0;
        end
      end
    end
  endgenerate

  // Slot still holding an unsent code when a second one lands
  wire lost = |(ev & pend & ~grant);

  // ==========================================================
  // Code output, one code per cycle
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      code_o <= 8'h00;
      code_valid_o <= 1'b0;
      code_numeric_o <= 1'b0;
    end
    else
    begin
      code_numeric_o <= ~numeric_verbose_select;
      code_valid_o <= (sel != SEL_NONE);
      if (sel != SEL_NONE)
      begin
        code_o <= pend_code[sel*8 +: 8];
      end
    end
  end

  // ==========================================================
  // Register file
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `MRCS_RST_CTRL;
      report_r <= `MRCS_RST_REPORT;
      dte_rate_r <= `MRCS_RST_DTE_RATE;
      last_code_r <= 8'h00;
      count_r <= 8'h00;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (wr_i)
      begin
        if (addr_i == `MRCS_OFS_CTRL)
        begin
          ctrl_r <= {1'b0, wdata_i[6:0]};
        end
        else if (addr_i == `MRCS_OFS_REPORT)
        begin
          report_r <= {4'h0, wdata_i[3:0]};
        end
        else if (addr_i == `MRCS_OFS_DTE_RATE)
        begin
          dte_rate_r <= wdata_i[4:0];
        end
      end
      if (sel != SEL_NONE)
      begin
        last_code_r <= pend_code[sel*8 +: 8];
        count_r <= count_r + 8'h01;
      end
      // Set wins over a write-one clear in the same cycle
      if (lost)
      begin
        overrun_r <= 1'b1;
      end
      else if (wr_i && addr_i == `MRCS_OFS_STATUS && wdata_i[`MRCS_STAT_OVERRUN])
      begin
        overrun_r <= 1'b0;
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (!rd_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (addr_i == `MRCS_OFS_CTRL)
    begin
      rdata_o <= ctrl_r;
    end
    else if (addr_i == `MRCS_OFS_REPORT)
    begin
      rdata_o <= report_r;
    end
    else if (addr_i == `MRCS_OFS_DTE_RATE)
    begin
      rdata_o <= {3'h0, dte_rate_r};
    end
    else if (addr_i == `MRCS_OFS_LAST_CODE)
    begin
      rdata_o <= last_code_r;
    end
    else if (addr_i == `MRCS_OFS_STATUS)
    begin
      rdata_o <= {overrun_r, pend};
    end
    else if (addr_i == `MRCS_OFS_COUNT)
    begin
      rdata_o <= count_r;
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end

endmodule // mrcs_selector

/* tb/mrcs_selector_sva.sv */
`timescale 1ns/1ps
// ==========
// Port checker
module mrcs_chk
(
  input wire clock_i,
  input wire rst_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire no_dial_tone_i,
  input wire busy_detect_i,
  input wire no_silence_timeout_i,
  input wire connect_i,
  input wire [7:0] connect_rate_code_i,
  input wire carrier_det_i,
  input wire [3:0] carrier_mod_i,
  input wire [4:0] carrier_rate_i,
  input wire compress_det_i,
  input wire [1:0] compress_type_i,
  input wire protocol_det_i,
  input wire [2:0] protocol_type_i,
  input wire [7:0] code_o,
  input wire code_valid_o
);
  wire [6:0] ev = {connect_i, compress_det_i, protocol_det_i, carrier_det_i,
    no_silence_timeout_i, busy_detect_i, no_dial_tone_i};
  reg [3:0] idle_r;
  // Lone event after eight quiet cycles: nothing else can be pending
  wire calm = (idle_r == 4'h8) && $onehot(ev);
  always @(posedge clock_i)
    if (rst_i)
      idle_r <= 4'h0;
    else if (|ev)
      idle_r <= 4'h0;
    else if (idle_r != 4'h8)
      idle_r <= idle_r + 4'h1;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property ($past(!rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero");
  a_code_hold: assert property (!code_valid_o |-> $stable(code_o))
    else $error("code changed without strobe");
  a_no_spurious: assert property (idle_r == 4'h8 |-> !code_valid_o)
    else $error("code without event");
  a_code_legal: assert property (code_valid_o |-> code_o inside {8'h01, 8'h03,
    [8'h05:8'h08], [8'h0a:8'h0f], [8'h18:8'h21], 8'h28, 8'h2a, 8'h2b, [8'h2e:8'h3c],
    8'h42, 8'h43, [8'h45:8'h46], 8'h4d, [8'h50:8'h54]})
    else $error("illegal code");
  a_dial_code: assert property (calm && no_dial_tone_i |=>
    !code_valid_o || code_o inside {8'h06, 8'h03}) else $error("bad dial code");
  a_busy_code: assert property (calm && busy_detect_i |=>
    !code_valid_o || code_o inside {8'h07, 8'h03}) else $error("bad busy code");
  a_noans_code: assert property (calm && no_silence_timeout_i |=>
    !code_valid_o || code_o == 8'h08) else $error("bad no-answer code");
  a_carrier_map: assert property (calm && carrier_det_i && carrier_mod_i == 4'h8
    && carrier_rate_i > 5'h02 |=> !code_valid_o || code_o == 8'h2c + $past(carrier_rate_i))
    else $error("bad carrier code");
  a_connect_code: assert property (calm && connect_i |=> !code_valid_o
    || code_o == 8'h01 || code_o == $past(connect_rate_code_i)) else $error("bad connect");
  a_prot_code: assert property (calm && protocol_det_i && protocol_type_i > 3'h1
    && protocol_type_i < 3'h7 |=> !code_valid_o || code_o == 8'h4e + $past(protocol_type_i))
    else $error("bad protocol code");
  a_comp_code: assert property (calm && compress_det_i && compress_type_i == 2'h2
    |=> !code_valid_o || code_o == 8'h43) else $error("bad compression code");
endmodule // mrcs_chk

bind mrcs_selector mrcs_chk u_chk (.clock_i, .rst_i, .rd_i, .rdata_o, .no_dial_tone_i,
  .busy_detect_i, .no_silence_timeout_i, .connect_i, .connect_rate_code_i, .carrier_det_i,
  .carrier_mod_i, .carrier_rate_i, .compress_det_i, .compress_type_i, .protocol_det_i,
  .protocol_type_i, .code_o, .code_valid_o);

/* tb/mrcs_dte_model.sv */
`timescale 1ns/1ps
// ==========
// Terminal side: counts every code it is handed
module mrcs_dte_model
(
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] code_i,
  input wire code_valid_i,
  output reg [7:0] rx_count_o,
  output reg [7:0] rx_last_o
);
  always @(posedge clock_i)
    if (rst_i)
    begin
      rx_count_o <= 8'h00;
      rx_last_o <= 8'h00;
    end
    else if (code_valid_i)
    begin
      rx_count_o <= rx_count_o + 8'h01;
      rx_last_o <= code_i;
    end
endmodule // mrcs_dte_model

/* tb/mrcs_selector_bench.sv */
`timescale 1ns/1ps
`include "mrcs_defs.vh"
module mrcs_selector_bench;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [6:0] ev = 7'h00;
  reg qmod = 1'b0;
  reg [3:0] md = 4'h0;
  reg [4:0] rt = 5'h00;
  reg [1:0] ct = 2'h0;
  reg [2:0] pt = 3'h0;
  reg [7:0] rc = 8'h00;
  wire [7:0] rdata;
  wire [7:0] code;
  wire cvalid;
  wire cnum;
  wire [7:0] rx_cnt;
  wire [7:0] rx_last;
  reg [7:0] cq[$];
  reg [7:0] rq[$];
  reg rd_pend = 1'b0;
  reg [7:0] tmp;
  reg [19:0] ctab [0:11] = '{20'h00028, 20'h1022a, 20'h2022b, 20'h3022e, 20'h4032f,
    20'h50430, 20'h50632, 20'h60531, 20'h60733, 20'h60834, 20'h70935, 20'h70a36};
  integer n_mismatch = 0;
  integer checks = 0;
  integer seed = 32'hb6d4;
  integer ncodes = 0;
  integer i;
  integer k;

  mrcs_selector uut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .no_dial_tone_i(ev[0]), .busy_detect_i(ev[1]),
    .quiet_answer_mod_i(qmod), .no_silence_timeout_i(ev[2]), .connect_i(ev[6]),
    .connect_rate_code_i(rc), .carrier_det_i(ev[3]), .carrier_mod_i(md),
    .carrier_rate_i(rt), .compress_det_i(ev[5]), .compress_type_i(ct),
    .protocol_det_i(ev[4]), .protocol_type_i(pt), .code_o(code), .code_valid_o(cvalid),
    .code_numeric_o(cnum));
  mrcs_dte_model u_dte (.clock_i(clock_i), .rst_i(rst_i), .code_i(code),
    .code_valid_i(cvalid), .rx_count_o(rx_cnt), .rx_last_o(rx_last));

  initial
    forever #50 clock_i = ~clock_i;

  // ==========
  // Shared tasks
  task cmp(input [8*5:1] nm, input [7:0] e, input [7:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  end
  endtask
  task rd_reg(input [7:0] a, input [7:0] e);
  begin
    rq.push_back(e);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
  end
  endtask
  task expect_code(input [7:0] c);
  begin
    cq.push_back(c);
    ncodes = ncodes + 1;
  end
  endtask
  // Pulses one event set, then lets every pending slot drain
  task fire(input [6:0] m, input [3:0] mo, input [4:0] r);
  begin
    @(posedge clock_i);
    ev <= m;
    md <= mo;
    rt <= r;
    @(posedge clock_i);
    ev <= 7'h00;
    repeat (10) @(posedge clock_i);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  // ==========
  // Result watcher
  always @(negedge clock_i)
  begin
    if (rd_pend)
      cmp("rdata", rq.pop_front(), rdata);
    rd_pend = rd;
    if (cvalid === 1'b1)
    begin
      tmp = (cq.size() != 0) ? cq.pop_front() : ~code;
      cmp("code", tmp, code);
    end
  end

  // ==========
  // Scenarios
  initial
  begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_reg(`MRCS_OFS_CTRL, `MRCS_RST_CTRL);
    rd_reg(`MRCS_OFS_REPORT, `MRCS_RST_REPORT);
    rd_reg(`MRCS_OFS_DTE_RATE, {3'h0, `MRCS_RST_DTE_RATE});
    rd_reg(8'h3c, 8'h00);
    cmp("num", 8'h00, {7'h00, cnum});
    wr_reg(`MRCS_OFS_CTRL, 8'h0c);
    wr_reg(`MRCS_OFS_REPORT, 8'h0f);
    wr_reg(`MRCS_OFS_LAST_CODE, 8'h55);
    rd_reg(`MRCS_OFS_CTRL, 8'h0c);
    rd_reg(`MRCS_OFS_LAST_CODE, 8'h00);
    cmp("num", 8'h01, {7'h00, cnum});
    for (i = 0; i < 12; i = i + 1)
    begin
      expect_code(ctab[i][7:0]);
      fire(7'h08, ctab[i][19:16], ctab[i][12:8]);
    end
    fire(7'h08, `MRCS_MOD_V32, `MRCS_RATE_7200);
    for (i = 3; i < 17; i = i + 1)
    begin
      expect_code(8'h2c + i[7:0]);
      fire(7'h08, `MRCS_MOD_V34, i[4:0]);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      ct <= i[1:0];
      expect_code(i == 0 ? 8'h45 : i == 1 ? 8'h42 : 8'h43);
      fire(7'h20, 4'h0, 5'h00);
    end
    for (i = 0; i < 7; i = i + 1)
    begin
      pt <= i[2:0];
      expect_code(i == 0 ? 8'h46 : i == 1 ? 8'h4d : 8'h4e + i[7:0]);
      fire(7'h10, 4'h0, 5'h00);
    end
    pt <= `MRCS_PROT_LAPM;
    expect_code(8'h34);
    expect_code(8'h4d);
    fire(7'h18, `MRCS_MOD_V34, `MRCS_RATE_14400);
    wr_reg(`MRCS_OFS_CTRL, 8'h14);
    fire(7'h08, `MRCS_MOD_V34, `MRCS_RATE_14400);
    for (i = 0; i < 4; i = i + 1)
    begin
      k = {$random(seed)} % 17;
      tmp = k == 0 ? 8'h05 : k < 7 ? 8'h09 + k[7:0] : 8'h11 + k[7:0];
      rc <= tmp;
      expect_code(tmp);
      fire(7'h40, 4'h0, 5'h00);
    end
    wr_reg(`MRCS_OFS_CTRL, 8'h04);
    wr_reg(`MRCS_OFS_DTE_RATE, {3'h0, `MRCS_RATE_2400});
    expect_code(rc);
    fire(7'h40, 4'h0, 5'h00);
    wr_reg(`MRCS_OFS_DTE_RATE, {3'h0, `MRCS_RATE_4800});
    expect_code(8'h01);
    fire(7'h40, 4'h0, 5'h00);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr_reg(`MRCS_OFS_CTRL, 8'h10 | i[7:0]);
      if (i == 0)
        expect_code(8'h03);
      if (i == 0)
        expect_code(8'h03);
      if (i == 2 || i == 4)
        expect_code(8'h06);
      if (i == 3 || i == 4)
        expect_code(8'h07);
      fire(7'h03, 4'h0, 5'h00);
    end
    rc <= 8'h09;
    expect_code(8'h01);
    fire(7'h40, 4'h0, 5'h00);
    qmod <= 1'b1;
    expect_code(8'h08);
    fire(7'h04, 4'h0, 5'h00);
    qmod <= 1'b0;
    fire(7'h04, 4'h0, 5'h00);
    // Second connect lands while the first still waits behind dial: overrun
    expect_code(8'h06);
    expect_code(8'h05);
    @(posedge clock_i);
    ev <= 7'h41;
    rc <= 8'h05;
    @(posedge clock_i);
    ev <= 7'h40;
    @(posedge clock_i);
    ev <= 7'h00;
    repeat (10) @(posedge clock_i);
    rd_reg(`MRCS_OFS_STATUS, 8'h80);
    wr_reg(`MRCS_OFS_STATUS, 8'h80);
    rd_reg(`MRCS_OFS_STATUS, 8'h00);
    wr_reg(`MRCS_OFS_REPORT, 8'h03);
    fire(7'h03, 4'h0, 5'h00);
    wr_reg(`MRCS_OFS_REPORT, 8'h0f);
    wr_reg(`MRCS_OFS_CTRL, 8'h34);
    expect_code(8'h06);
    fire(7'h71, 4'h0, 5'h00);
    rd_reg(`MRCS_OFS_LAST_CODE, 8'h06);
    rd_reg(`MRCS_OFS_COUNT, ncodes[7:0]);
    k = 0;
    while ((cq.size() != 0 || rq.size() != 0) && k < 50)
    begin
      @(posedge clock_i);
      k = k + 1;
    end
    if (cq.size() != 0 || rq.size() != 0)
      n_mismatch = n_mismatch + 1;
    cmp("rxcnt", ncodes[7:0], rx_cnt);
    report_and_stop;
  end
endmodule // mrcs_selector_bench
